// >>> common/vmc_pkg.sv
// Shared types and constants for the virtualization mode and CSR redirect block.
package vmc_pkg;

    // Nominal privilege codes; code 2'b10 is reserved and never taken.
    typedef enum logic [1:0] {
        VMC_LVL_U = 2'b00,
        VMC_LVL_S = 2'b01,
        VMC_LVL_M = 2'b11
    } vmc_lvl_e;

    // Reset values.
    localparam logic VMC_VIRT_RST = 1'b0;
    localparam logic VMC_HYP_EN_RST = 1'b1;
    localparam vmc_lvl_e VMC_LVL_RST = VMC_LVL_M;

    // Position of the hypervisor enable bit in the ISA feature register.
    localparam int VMC_ISA_HYP_BIT = 7;

    // Structural figures the block is built for.
    localparam int VMC_REGFILE_ENTRIES = 32;
    localparam int VMC_PT_LEVELS_32 = 2;
    localparam int VMC_PT_LEVELS_64 = 3;

    // Privilege ranking values, larger is more privileged.
    localparam logic [2:0] VMC_RANK_M = 3'h4;
    localparam logic [2:0] VMC_RANK_HS = 3'h3;
    localparam logic [2:0] VMC_RANK_VS = 3'h2;
    localparam logic [2:0] VMC_RANK_U = 3'h1;
    localparam logic [2:0] VMC_RANK_VU = 3'h0;

    // CSR address classes: the page nibble in bits 11:8 and the level field in bits 9:8.
    localparam logic [3:0] VMC_PAGE_SUP = 4'h1;
    localparam logic [3:0] VMC_PAGE_GUEST = 4'h2;
    localparam logic [3:0] VMC_PAGE_HYP = 4'h6;
    localparam logic [1:0] VMC_FIELD_MACH = 2'h3;
    localparam logic [11:0] VMC_GUEST_DELTA = 12'h100;

    // Supervisor registers that own a guest copy at address plus the guest delta.
    localparam int VMC_NCOPY = 9;
    localparam logic [VMC_NCOPY*12-1:0] VMC_COPY_LIST = {
        12'h100, 12'h104, 12'h105, 12'h140, 12'h141,
        12'h142, 12'h143, 12'h144, 12'h180
    };

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
    } vmc_csr_req_s;

    typedef struct packed {
        logic done;
        logic write;
        logic [11:0] addr;
        logic virt_instr_exc;
        logic illegal_exc;
    } vmc_csr_resp_s;

endpackage

// >>> design/vmc_virt_mode.sv
// Virtualization mode, privilege tracking and guest CSR redirection for one hart.
//
// Functional notes
// R1 - Hypervisor enabled only while ISA bit 7 set.
// R2 - Hypervisor enable bit left software writable.
// R3 - Full 32-entry integer register file required.
// R4 - Machine trap value register holds written values.
// R5 - Two-level paging on 32-bit, three-level on 64-bit; the 64-bit check accepts three or more levels.
// R6 - Virtual flag implies guest levels; clear implies host.
// R7 - Two-stage translation active exactly while virtualized.
// R8 - Nominal privilege U or S for both worlds.
// R9 - Rank host supervisor above guest supervisor above guest user.
// R10 - Guest supervisor interrupts disabled at host user.
// R11 - Hypervisor registers reachable from host, not guest supervisor.
// R12 - Virtualized supervisor accesses go to guest copies.
// R13 - Virtualized direct guest-copy access raises virtual-instruction.
// R14 - Direct guest-copy access from user level is illegal.
// R15 - Guest copies reachable directly only from machine or host.
// R16 - Host copies keep contents, inert while virtualized.
// R17 - Guest copies inert while not virtualized.
// R18 - Uncopied supervisor registers serve guest levels too.
// R19 - Virtual flag cleared on reset.
`timescale 1ns/1ns
module vmc_virt_mode #(
    parameter int XLEN = 64,
    parameter int REGFILE_ENTRIES = 32,
    parameter int PT_LEVELS = 3,
    parameter bit HYP_WRITABLE = 1'b1
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic isa_wr_en,
    input wire logic isa_wr_hyp,
    input wire logic mode_wr_en,
    input wire logic [1:0] mode_wr_priv,
    input wire logic mode_wr_virt,
    input wire logic mtval_wr_en,
    input wire logic [XLEN-1:0] mtval_wr_data,
    input wire vmc_pkg::vmc_csr_req_s csr_req,
    input wire logic guest_irq_pend,
    input wire logic guest_sie,
    output logic hyp_en,
    output logic [1:0] nominal_priv,
    output logic virt_mode,
    output logic two_stage_en,
    output logic guest_bank_sel,
    output logic [2:0] priv_rank,
    output logic guest_irq_take,
    output logic [XLEN-1:0] mtval,
    output vmc_pkg::vmc_csr_resp_s csr_resp
);

    // Elaboration checks on the structure this block assumes.
    generate
        if (REGFILE_ENTRIES != vmc_pkg::VMC_REGFILE_ENTRIES)
        begin : g_rf_chk
            $error("Hypervisor support needs the full integer register file."); // R3
        end
        if (XLEN != 32 && XLEN != 64)
        begin : g_xlen_chk
            $error("Only 32-bit and 64-bit harts are served.");
        end
        if ((XLEN == 32 && PT_LEVELS != vmc_pkg::VMC_PT_LEVELS_32) ||
            (XLEN == 64 && PT_LEVELS < vmc_pkg::VMC_PT_LEVELS_64))
        begin : g_pt_chk
            $error("Page translation depth does not suit the hart width."); // R5
        end
    endgenerate

    typedef struct packed {
        logic [1:0] priv;
        logic virt;
        logic hyp_en;
        logic two_stage;
        logic guest_bank;
        logic [2:0] rank;
        logic irq_take;
        logic [XLEN-1:0] mtval;
        vmc_pkg::vmc_csr_resp_s resp;
    } vmc_state_s;

    vmc_state_s st_r;
    vmc_state_s st_nxt;

    // Supervisor address that owns a guest copy; matched by a generate loop.
    logic [vmc_pkg::VMC_NCOPY-1:0] sup_hit;
    logic [vmc_pkg::VMC_NCOPY-1:0] guest_hit;
    genvar gi;
    generate
        for (gi = 0; gi < vmc_pkg::VMC_NCOPY; gi++)
        begin : g_copy
            localparam logic [11:0] SUP_A = vmc_pkg::VMC_COPY_LIST[gi*12 +: 12];
            assign sup_hit[gi] = (csr_req.addr == SUP_A);
            assign guest_hit[gi] = (csr_req.addr == SUP_A + vmc_pkg::VMC_GUEST_DELTA);
        end
    endgenerate

    function automatic logic [2:0] rank_of(input logic [1:0] priv, input logic virt);
        logic [2:0] r;
        r = vmc_pkg::VMC_RANK_M;
        if (priv == vmc_pkg::VMC_LVL_S)
        begin
            r = virt ? vmc_pkg::VMC_RANK_VS : vmc_pkg::VMC_RANK_HS; // R9
        end
        else if (priv == vmc_pkg::VMC_LVL_U)
        begin
            r = virt ? vmc_pkg::VMC_RANK_VU : vmc_pkg::VMC_RANK_U; // R9
        end
        return r;
    endfunction

    logic req_is_sup_copy;
    logic req_is_guest;
    logic req_is_hyp;
    logic req_is_sup_plain;
    logic req_is_mach;
    logic cur_user;
    logic cur_mach;

    always_comb
    begin
        req_is_sup_copy = |sup_hit;
        req_is_guest = |guest_hit;
        req_is_hyp = (csr_req.addr[11:8] == vmc_pkg::VMC_PAGE_HYP);
        req_is_sup_plain = (csr_req.addr[11:8] == vmc_pkg::VMC_PAGE_SUP) && !req_is_sup_copy;
        req_is_mach = (csr_req.addr[9:8] == vmc_pkg::VMC_FIELD_MACH);
        cur_user = (st_r.priv == vmc_pkg::VMC_LVL_U);
        cur_mach = (st_r.priv == vmc_pkg::VMC_LVL_M);
    end

    always_comb
    begin
        st_nxt = st_r;
        // Software may switch the extension off; it takes effect from the next cycle.
        if (isa_wr_en && HYP_WRITABLE)
        begin
            st_nxt.hyp_en = isa_wr_hyp; // R1 R2
        end
        // A reserved privilege code is ignored rather than guessed at.
        if (mode_wr_en && mode_wr_priv != 2'h2)
        begin
            st_nxt.priv = mode_wr_priv;
            st_nxt.virt = mode_wr_virt && (mode_wr_priv != vmc_pkg::VMC_LVL_M); // R6
        end
        if (!st_nxt.hyp_en)
        begin
            st_nxt.virt = 1'b0; // R1 R6
        end
        st_nxt.two_stage = st_nxt.virt; // R7
        st_nxt.guest_bank = st_nxt.virt; // R16 R17
        st_nxt.rank = rank_of(st_nxt.priv, st_nxt.virt); // R8 R9
        // Guest interrupts are only taken inside the guest; host user blocks them outright.
        st_nxt.irq_take = guest_irq_pend && st_r.virt &&
                          (cur_user || guest_sie); // R10
        if (mtval_wr_en)
        begin
            st_nxt.mtval = mtval_wr_data; // R4
        end
        st_nxt.resp = '0;
        if (csr_req.valid)
        begin
            st_nxt.resp.done = 1'b1;
            st_nxt.resp.write = csr_req.write;
            st_nxt.resp.addr = csr_req.addr;
            if (req_is_guest)
            begin
                if (cur_user || !st_r.hyp_en)
                begin
                    st_nxt.resp.illegal_exc = 1'b1; // R14 R15
                end
                else if (st_r.virt)
                begin
                    st_nxt.resp.virt_instr_exc = 1'b1; // R13
                end
            end
            else if (req_is_hyp)
            begin
                if (cur_user || !st_r.hyp_en)
                begin
                    st_nxt.resp.illegal_exc = 1'b1; // R11
                end
                else if (st_r.virt)
                begin
                    st_nxt.resp.virt_instr_exc = 1'b1; // R11
                end
            end
            else if (req_is_sup_copy)
            begin
                if (cur_user)
                begin
                    st_nxt.resp.illegal_exc = 1'b1;
                end
                else if (st_r.virt)
                begin
                    st_nxt.resp.addr = csr_req.addr + vmc_pkg::VMC_GUEST_DELTA; // R12
                end
            end
            else if (req_is_sup_plain)
            begin
                // Guest supervisor stands in for host supervisor here.
                st_nxt.resp.illegal_exc = cur_user; // R18
            end
            else if (req_is_mach)
            begin
                st_nxt.resp.illegal_exc = !cur_mach;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_r <= '0;
            st_r.priv <= vmc_pkg::VMC_LVL_RST;
            st_r.virt <= vmc_pkg::VMC_VIRT_RST; // R19
            st_r.hyp_en <= vmc_pkg::VMC_HYP_EN_RST;
            st_r.rank <= vmc_pkg::VMC_RANK_M;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign hyp_en = st_r.hyp_en;
    assign nominal_priv = st_r.priv; // R8
    assign virt_mode = st_r.virt;
    assign two_stage_en = st_r.two_stage;
    assign guest_bank_sel = st_r.guest_bank;
    assign priv_rank = st_r.rank;
    assign guest_irq_take = st_r.irq_take;
    assign mtval = st_r.mtval;
    assign csr_resp = st_r.resp;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    virt_level_a: assert property (virt_mode |-> nominal_priv != vmc_pkg::VMC_LVL_M) // R6
        else $error("Virtual flag set at machine level.");

    two_stage_a: assert property (two_stage_en == virt_mode) // R7
        else $error("Two-stage translation disagrees with the virtual flag.");

    hyp_off_a: assert property (!hyp_en |-> !virt_mode) // R1
        else $error("Virtualized with the hypervisor disabled.");

    hyp_write_a: assert property (isa_wr_en && HYP_WRITABLE |=> hyp_en == $past(isa_wr_hyp)) // R2
        else $error("Hypervisor enable did not take the written value.");

    mtval_hold_a: assert property (mtval_wr_en |=> mtval == $past(mtval_wr_data)) // R4
        else $error("Trap value register lost the written value.");

    rank_order_a: assert property (
        virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S |-> priv_rank == 3'h2) // R9
        else $error("Guest supervisor rank wrong.");

    irq_user_a: assert property (
        nominal_priv == vmc_pkg::VMC_LVL_U && !virt_mode |=> !guest_irq_take) // R10
        else $error("Guest interrupt taken at host user level.");

    redirect_a: assert property (
        csr_req.valid && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S && (|sup_hit)
        |=> csr_resp.done && csr_resp.addr == $past(csr_req.addr) + 12'h100 &&
            !csr_resp.virt_instr_exc && !csr_resp.illegal_exc) // R12
        else $error("Supervisor access not redirected to the guest copy.");

    guest_direct_a: assert property (
        csr_req.valid && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S && (|guest_hit)
        |=> csr_resp.virt_instr_exc && !csr_resp.illegal_exc) // R13
        else $error("Direct guest copy access did not raise virtual-instruction.");

    guest_user_a: assert property (
        csr_req.valid && nominal_priv == vmc_pkg::VMC_LVL_U && (|guest_hit)
        |=> csr_resp.illegal_exc && !csr_resp.virt_instr_exc) // R14 R15
        else $error("User access to a guest copy not illegal.");

    host_direct_a: assert property (
        csr_req.valid && !virt_mode && hyp_en && nominal_priv != vmc_pkg::VMC_LVL_U &&
        (|guest_hit) |=> !csr_resp.illegal_exc && !csr_resp.virt_instr_exc) // R15
        else $error("Host access to a guest copy refused.");

    hyp_guest_a: assert property (
        csr_req.valid && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S &&
        csr_req.addr[11:8] == 4'h6 |=> csr_resp.virt_instr_exc) // R11
        else $error("Guest supervisor reached a hypervisor register.");

    bank_sel_a: assert property (guest_bank_sel == virt_mode) // R16 R17
        else $error("Register bank select disagrees with the virtual flag.");

    plain_sup_a: assert property (
        csr_req.valid && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S &&
        csr_req.addr[11:8] == 4'h1 && !(|sup_hit) |=> !csr_resp.illegal_exc &&
        csr_resp.addr == $past(csr_req.addr)) // R18
        else $error("Uncopied supervisor register refused to the guest.");

    resp_pulse_a: assert property (!csr_req.valid |=> !csr_resp.done)
        else $error("Answer without a request.");

    // The default disable would hide the reset itself, so this check opts out of it.
    reset_virt_a: assert property (@(posedge clk) disable iff (1'b0) // R19
        sys_rst |=> !virt_mode && nominal_priv == vmc_pkg::VMC_LVL_M)
        else $error("Reset left the hart virtualized or below machine level.");

    hyp_off_csr_a: assert property ( // R1 R11 R15
        csr_req.valid && !hyp_en &&
        ((|guest_hit) || csr_req.addr[11:8] == vmc_pkg::VMC_PAGE_HYP) |=> csr_resp.illegal_exc)
        else $error("Hypervisor register reached with the extension disabled.");

    hyp_page_user_a: assert property ( // R11
        csr_req.valid && nominal_priv == vmc_pkg::VMC_LVL_U &&
        csr_req.addr[11:8] == vmc_pkg::VMC_PAGE_HYP |=> csr_resp.illegal_exc)
        else $error("User level reached a hypervisor register.");

    mach_field_a: assert property ( // R15
        csr_req.valid && nominal_priv != vmc_pkg::VMC_LVL_M &&
        csr_req.addr[9:8] == vmc_pkg::VMC_FIELD_MACH |=> csr_resp.illegal_exc)
        else $error("Machine register reached below machine level.");

    vu_sup_a: assert property ( // R12 R14
        csr_req.valid && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_U && (|sup_hit)
        |=> csr_resp.illegal_exc && !csr_resp.virt_instr_exc)
        else $error("Guest user reached a supervisor register.");

    rank_host_a: assert property ( // R9
        !virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S |-> priv_rank == vmc_pkg::VMC_RANK_HS)
        else $error("Host supervisor rank wrong.");

    rank_vu_a: assert property ( // R9
        virt_mode && nominal_priv == vmc_pkg::VMC_LVL_U |-> priv_rank == vmc_pkg::VMC_RANK_VU)
        else $error("Guest user rank wrong.");

    irq_vu_a: assert property ( // R10
        guest_irq_pend && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_U |=> guest_irq_take)
        else $error("Guest interrupt not taken at guest user level.");

    irq_sie_a: assert property ( // R10
        guest_irq_pend && guest_sie && virt_mode && nominal_priv == vmc_pkg::VMC_LVL_S
        |=> guest_irq_take)
        else $error("Enabled guest interrupt not taken at guest supervisor level.");

    enter_guest_c: cover property (!virt_mode ##1 virt_mode);
    redirect_c: cover property (csr_req.valid && virt_mode && (|sup_hit));
    virt_exc_c: cover property (csr_resp.virt_instr_exc);
    irq_take_c: cover property (guest_irq_take);
    hyp_off_c: cover property (csr_req.valid && !hyp_en);

endmodule

// >>> verif/vmc_virt_mode_tb.sv
// Self-checking testbench for the virtualization mode and CSR redirect block.
`timescale 1ns/1ns
module vmc_virt_mode_tb;
    logic clk;
    logic sys_rst;
    logic isa_wr_en;
    logic isa_wr_hyp;
    logic mode_wr_en;
    logic [1:0] mode_wr_priv;
    logic mode_wr_virt;
    logic mtval_wr_en;
    logic [63:0] mtval_wr_data;
    vmc_pkg::vmc_csr_req_s csr_req;
    logic guest_irq_pend;
    logic guest_sie;
    logic hyp_en;
    logic [1:0] nominal_priv;
    logic virt_mode;
    logic two_stage_en;
    logic guest_bank_sel;
    logic [2:0] priv_rank;
    logic guest_irq_take;
    logic [63:0] mtval;
    vmc_pkg::vmc_csr_resp_s csr_resp;
    int fails;
    int n_compared;
    localparam logic [1:0] PU = 2'b00;
    localparam logic [1:0] PS = 2'b01;
    localparam logic [1:0] PM = 2'b11;

    vmc_virt_mode vmc_virt_mode_inst (
        .clk(clk), .sys_rst(sys_rst), .isa_wr_en(isa_wr_en), .isa_wr_hyp(isa_wr_hyp),
        .mode_wr_en(mode_wr_en), .mode_wr_priv(mode_wr_priv), .mode_wr_virt(mode_wr_virt),
        .mtval_wr_en(mtval_wr_en), .mtval_wr_data(mtval_wr_data), .csr_req(csr_req),
        .guest_irq_pend(guest_irq_pend), .guest_sie(guest_sie), .hyp_en(hyp_en),
        .nominal_priv(nominal_priv), .virt_mode(virt_mode), .two_stage_en(two_stage_en),
        .guest_bank_sel(guest_bank_sel), .priv_rank(priv_rank),
        .guest_irq_take(guest_irq_take), .mtval(mtval), .csr_resp(csr_resp)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [63:0] exp, input logic [63:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            fails++;
        end
    endtask

    task automatic step();
        @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [2:0] exp_rank(input logic [1:0] p, input logic v);
        if (p == PM)
            return vmc_pkg::VMC_RANK_M;
        if (p == PS)
            return v ? vmc_pkg::VMC_RANK_VS : vmc_pkg::VMC_RANK_HS;
        return v ? vmc_pkg::VMC_RANK_VU : vmc_pkg::VMC_RANK_U;
    endfunction

    task automatic check_state(input logic [1:0] p, input logic v);
        check_val("nominal_priv", {62'h0, p}, {62'h0, nominal_priv});
        check_val("virt_mode", {63'h0, v}, {63'h0, virt_mode});
        check_val("two_stage_en", {63'h0, v}, {63'h0, two_stage_en});
        check_val("guest_bank_sel", {63'h0, v}, {63'h0, guest_bank_sel});
        check_val("priv_rank", {61'h0, exp_rank(p, v)}, {61'h0, priv_rank});
    endtask

    // The enable is dropped and a cycle passes, so back-to-back calls never reassign it at once.
    task automatic set_mode(input logic [1:0] p, input logic v);
        mode_wr_en = 1'b1;
        mode_wr_priv = p;
        mode_wr_virt = v;
        step();
        mode_wr_en = 1'b0;
        step();
    endtask

    task automatic isa_write(input logic h);
        isa_wr_en = 1'b1;
        isa_wr_hyp = h;
        step();
        isa_wr_en = 1'b0;
        step();
    endtask

    task automatic test_reset();
        check_state(PM, 1'b0);
        check_val("hyp_en", 64'h1, {63'h0, hyp_en});
        step();
        check_state(PM, 1'b0);
        $display("test reset done");
    endtask

    task automatic test_modes();
        logic [1:0] plist [3];
        plist = '{PU, PS, PM};
        for (int i = 0; i < 3; i++)
        begin
            for (int v = 0; v < 2; v++)
            begin
                set_mode(plist[i], v[0]);
                check_state(plist[i], v[0] && plist[i] != PM);
            end
        end
        set_mode(PS, 1'b1);
        set_mode(2'b10, 1'b0);
        check_state(PS, 1'b1);
        $display("test modes done");
    endtask

    task automatic test_isa();
        set_mode(PS, 1'b1);
        isa_write(1'b0);
        check_val("hyp_en", 64'h0, {63'h0, hyp_en});
        check_state(PS, 1'b0);
        set_mode(PS, 1'b1);
        check_state(PS, 1'b0);
        isa_write(1'b1);
        check_val("hyp_en", 64'h1, {63'h0, hyp_en});
        $display("test isa done");
    endtask

    task automatic test_mtval();
        mtval_wr_en = 1'b1;
        mtval_wr_data = 64'ha5c3_0f1e_7d2b_9684;
        step();
        mtval_wr_en = 1'b0;
        step();
        check_val("mtval", 64'ha5c3_0f1e_7d2b_9684, mtval);
        $display("test mtval done");
    endtask

    task automatic csr_case(input logic [1:0] p, input logic v, input logic [11:0] a,
                            input logic [11:0] ea, input logic evi, input logic eil);
        set_mode(p, v);
        csr_req = '{valid: 1'b1, write: a[0], addr: a};
        step();
        check_val("resp.done", 64'h1, {63'h0, csr_resp.done});
        check_val("resp.write", {63'h0, a[0]}, {63'h0, csr_resp.write});
        check_val("resp.addr", {52'h0, ea}, {52'h0, csr_resp.addr});
        check_val("resp.virt_exc", {63'h0, evi}, {63'h0, csr_resp.virt_instr_exc});
        check_val("resp.illegal", {63'h0, eil}, {63'h0, csr_resp.illegal_exc});
        csr_req.valid = 1'b0;
        step();
    endtask

    task automatic test_csr();
        csr_case(PS, 1'b1, 12'h141, 12'h241, 1'b0, 1'b0);
        csr_case(PS, 1'b1, 12'h180, 12'h280, 1'b0, 1'b0);
        csr_case(PS, 1'b1, 12'h241, 12'h241, 1'b1, 1'b0);
        csr_case(PU, 1'b1, 12'h240, 12'h240, 1'b0, 1'b1);
        csr_case(PU, 1'b0, 12'h205, 12'h205, 1'b0, 1'b1);
        csr_case(PS, 1'b0, 12'h241, 12'h241, 1'b0, 1'b0);
        csr_case(PM, 1'b0, 12'h200, 12'h200, 1'b0, 1'b0);
        csr_case(PS, 1'b0, 12'h141, 12'h141, 1'b0, 1'b0);
        csr_case(PS, 1'b1, 12'h600, 12'h600, 1'b1, 1'b0);
        csr_case(PS, 1'b0, 12'h603, 12'h603, 1'b0, 1'b0);
        csr_case(PS, 1'b1, 12'h10a, 12'h10a, 1'b0, 1'b0);
        csr_case(PU, 1'b1, 12'h10a, 12'h10a, 1'b0, 1'b1);
        csr_case(PU, 1'b1, 12'h141, 12'h141, 1'b0, 1'b1);
        csr_case(PU, 1'b0, 12'h600, 12'h600, 1'b0, 1'b1);
        csr_case(PS, 1'b0, 12'h300, 12'h300, 1'b0, 1'b1);
        csr_case(PM, 1'b0, 12'h300, 12'h300, 1'b0, 1'b0);
        isa_write(1'b0);
        csr_case(PS, 1'b0, 12'h241, 12'h241, 1'b0, 1'b1);
        csr_case(PS, 1'b0, 12'h600, 12'h600, 1'b0, 1'b1);
        isa_write(1'b1);
        $display("test csr done");
    endtask

    task automatic irq_case(input logic [1:0] p, input logic v, input logic s, input logic e);
        set_mode(p, v);
        guest_irq_pend = 1'b1;
        guest_sie = s;
        step();
        check_val("guest_irq_take", {63'h0, e}, {63'h0, guest_irq_take});
    endtask

    // A reset taken from inside the guest must bring the hart back to machine level.
    task automatic test_rst_mid();
        set_mode(PS, 1'b1);
        sys_rst = 1'b1;
        step();
        sys_rst = 1'b0;
        check_state(PM, 1'b0);
        check_val("hyp_en", 64'h1, {63'h0, hyp_en});
        check_val("mtval", 64'h0, mtval);
        step();
        check_state(PM, 1'b0);
        check_val("guest_irq_take", 64'h0, {63'h0, guest_irq_take});
        $display("test mid-run reset done");
    endtask

    // Pending stays high throughout, so only level and enable decide the outcome.
    task automatic test_irq();
        irq_case(PU, 1'b0, 1'b1, 1'b0);
        irq_case(PS, 1'b1, 1'b1, 1'b1);
        irq_case(PS, 1'b1, 1'b0, 1'b0);
        irq_case(PU, 1'b1, 1'b0, 1'b1);
        $display("test irq done");
    endtask

    initial
    begin
        fails = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        {isa_wr_en, isa_wr_hyp, mode_wr_en, mode_wr_virt, mtval_wr_en} = 5'h0;
        mode_wr_priv = 2'h0;
        mtval_wr_data = 64'h0;
        csr_req = '0;
        guest_irq_pend = 1'b0;
        guest_sie = 1'b0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        sys_rst = 1'b0;
        test_reset();
        test_modes();
        test_isa();
        test_mtval();
        test_csr();
        test_irq();
        test_rst_mid();
        finish_test();
    end

    initial
    begin
        #200000;
        fails++;
        finish_test();
    end
endmodule
